// [rtl/audio_codec_pkg.sv]
// shared constants, codes and helpers for the audio codec bus controller
package audio_codec_pkg;

	// register offsets inside the 256-byte region
	localparam int         OFFSET_W        = 8;
	localparam logic [7:0] OFF_PLAY_DATA   = 8'h00;
	localparam logic [7:0] OFF_REC_DATA    = 8'h04;
	localparam logic [7:0] OFF_STATUS      = 8'h08;
	localparam logic [7:0] OFF_CONTROL     = 8'h0c;
	localparam logic [7:0] OFF_CODEC_ADDR  = 8'h10;
	localparam logic [7:0] OFF_CODEC_WDATA = 8'h14;
	localparam logic [7:0] OFF_CODEC_RDATA = 8'h18;

	// status register bit positions
	localparam int ST_PLAY_FULL   = 0;
	localparam int ST_PLAY_EMPTY  = 1;
	localparam int ST_REC_FULL    = 2;
	localparam int ST_REC_EMPTY   = 3;
	localparam int ST_REC_OVERRUN = 4;
	localparam int ST_UNDERRUN    = 5;
	localparam int ST_CODEC_READY = 6;
	localparam int ST_ACCESS_DONE = 7;

	// control register bits, self clearing
	localparam int CTRL_PLAY_FLUSH = 0;
	localparam int CTRL_REC_FLUSH  = 1;

	// codec address register: index plus read flag on top
	localparam int CODEC_INDEX_W = 7;

	// sample buffers
	localparam int SAMPLE_W   = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int LEVEL_W    = $clog2(FIFO_DEPTH + 1);

	// serial frame: one 16-bit tag slot, then twelve 20-bit slots
	localparam int         TAG_W         = 16;
	localparam int         SLOT_W        = 20;
	localparam int         SAMPLE_LSB    = 4;
	localparam logic [3:0] SLOT_TAG      = 4'h0;
	localparam logic [3:0] SLOT_ADDR     = 4'h1;
	localparam logic [3:0] SLOT_DATA     = 4'h2;
	localparam logic [3:0] SLOT_LEFT     = 4'h3;
	localparam logic [3:0] SLOT_RIGHT    = 4'h4;
	localparam logic [3:0] SLOT_LAST     = 4'hc;
	localparam logic [4:0] TAG_LAST_BIT  = 5'h0f;
	localparam logic [4:0] SLOT_LAST_BIT = 5'h13;

	// tag slot bit positions
	localparam int TAG_FRAME = 15;
	localparam int TAG_ADDR  = 14;
	localparam int TAG_DATA  = 13;
	localparam int TAG_LEFT  = 12;
	localparam int TAG_RIGHT = 11;

	// interrupt threshold selector codes
	localparam logic [2:0] LVL_NONE       = 3'h0;
	localparam logic [2:0] LVL_EMPTY      = 3'h1;
	localparam logic [2:0] LVL_HALF_EMPTY = 3'h2;
	localparam logic [2:0] LVL_HALF_FULL  = 3'h3;
	localparam logic [2:0] LVL_FULL       = 3'h4;

	// fill-level limits
	localparam logic [LEVEL_W-1:0] HALF_EMPTY_MAX = LEVEL_W'(7);
	localparam logic [LEVEL_W-1:0] HALF_FULL_MIN  = LEVEL_W'(8);
	localparam logic [LEVEL_W-1:0] LEVEL_FULL     = LEVEL_W'(FIFO_DEPTH);
	localparam logic [LEVEL_W-1:0] PAIR_WORDS     = LEVEL_W'(2);

	// threshold test shared by both directions
	function automatic logic thresholdMet(input logic [2:0] sel, input logic [LEVEL_W-1:0] level);
		case (sel)
			LVL_EMPTY:      thresholdMet = (level == '0);
			LVL_HALF_EMPTY: thresholdMet = (level <= HALF_EMPTY_MAX);
			LVL_HALF_FULL:  thresholdMet = (level >= HALF_FULL_MIN);
			LVL_FULL:       thresholdMet = (level == LEVEL_FULL);
			default:        thresholdMet = 1'b0;
		endcase
	endfunction

endpackage

// [rtl/sample_fifo.sv]
// single-clock sample fifo with flush and fill level
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
	import audio_codec_pkg::*;
#(
	parameter int WIDTH = SAMPLE_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic                       clock,
	input  wire logic                       srst,
	input  wire logic                       flush,
	input  wire logic                       pushValid,
	input  wire logic [WIDTH-1:0]           pushData,
	output logic                            pushReady,
	output logic                            popValid,
	input  wire logic                       popReady,
	output logic [WIDTH-1:0]                popData,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	// pointers and count; depth is a power of two so pointers wrap
	typedef struct packed {
		logic [PTR_W-1:0] wrPtr;
		logic [PTR_W-1:0] rdPtr;
		logic [CNT_W-1:0] count;
	} fifo_state_s;

	fifo_state_s      q;      // registered state
	fifo_state_s      n;      // next state
	logic [WIDTH-1:0] mem [DEPTH]; // sample storage
	logic             doPush; // accepted write
	logic             doPop;  // accepted read

	assign pushReady = (q.count != CNT_W'(DEPTH));
	assign popValid  = (q.count != '0);
	assign popData   = mem[q.rdPtr];
	assign level     = q.count;
	assign doPush    = pushValid & pushReady & ~flush;
	assign doPop     = popReady & popValid & ~flush;

	// pointer and count update, flush empties
	always_comb begin
		n = q;
		if (flush) begin
			n = '0;
		end else begin
			if (doPush) begin
				n.wrPtr = PTR_W'(q.wrPtr + 1'b1);
			end
			if (doPop) begin
				n.rdPtr = PTR_W'(q.rdPtr + 1'b1);
			end
			n.count = CNT_W'(q.count + CNT_W'(doPush) - CNT_W'(doPop));
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// storage write, no reset needed
	always_ff @(posedge clock) begin
		if (doPush) begin
			mem[q.wrPtr] <= pushData;
		end
	end
endmodule
`default_nettype wire

// [rtl/audio_codec_bus_controller.sv]
// apb slave that drives an audio codec serial link with sample buffers
`timescale 1ns/1ps
`default_nettype none
module audio_codec_bus_controller
	import audio_codec_pkg::*;
#(
	parameter int                         busAddressWidth         = 32,
	parameter int                         busDataWidth            = 32,
	parameter logic [busAddressWidth-1:0] regionStartAddress      = 32'h0000_0000,
	parameter logic [busAddressWidth-1:0] regionEndAddress        = 32'h0000_00ff,
	parameter bit                         playbackEnable          = 1'b1,
	parameter bit                         recordEnable            = 1'b1,
	parameter logic [2:0]                 playbackIrqThresholdSel = LVL_HALF_EMPTY,
	parameter logic [2:0]                 recordIrqThresholdSel   = LVL_HALF_FULL
)(
	input  wire logic                       clock,
	input  wire logic                       srst,
	input  wire logic [busAddressWidth-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [busDataWidth-1:0]    pwdata,
	output var  logic [busDataWidth-1:0]    prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	output var  logic                       playbackIrq,
	output var  logic                       recordIrq,
	input  wire logic                       codecBitClock,
	output var  logic                       frameSync,
	output var  logic                       serialToCodec,
	input  wire logic                       serialFromCodec
);
	// address bits that vary inside the region
	localparam logic [busAddressWidth-1:0] REGION_MASK = regionEndAddress - regionStartAddress;

	// all controller state
	typedef struct packed {
		logic [busDataWidth-1:0]  prdata;       // read data to bus
		logic                     pready;       // access phase answer
		logic                     pslverr;      // error answer
		logic                     playIrq;      // playback level interrupt
		logic                     recIrq;       // record level interrupt
		logic                     sync;         // frame sync pin
		logic                     sdo;          // serial pin to codec
		logic [2:0]               clkSync;      // bit clock synchroniser
		logic [2:0]               dinSync;      // serial input synchroniser
		logic                     clkLevel;     // accepted bit clock level
		logic [3:0]               slot;         // slot being shifted
		logic [4:0]               slotBit;      // bit in slot, counts down
		logic [TAG_W-1:0]         outTag;       // outgoing tag slot
		logic [SLOT_W-1:0]        outAddr;      // outgoing command address slot
		logic [SLOT_W-1:0]        outData;      // outgoing command data slot
		logic [SAMPLE_W-1:0]      outLeft;      // outgoing left sample
		logic [SAMPLE_W-1:0]      outRight;     // outgoing right sample
		logic                     takeRight;    // second pop of a pair due
		logic                     playing;      // playback has started
		logic                     underrun;     // sticky playback underrun
		logic                     overrun;      // sticky record overrun
		logic [SLOT_W-1:0]        inShift;      // incoming shift register
		logic [TAG_W-1:0]         inTag;        // tag of incoming frame
		logic                     codecReady;   // codec reports ready
		logic                     accessDone;   // codec register access over
		logic                     pending;      // command waits for a frame
		logic                     inFlight;     // command sent, not finished
		logic [CODEC_INDEX_W:0]   cmdAddr;      // read flag and register index
		logic [SAMPLE_W-1:0]      cmdWdata;     // codec write data
		logic [SAMPLE_W-1:0]      codecRdata;   // codec read data
		logic                     playFlush;    // playback flush pulse
		logic                     recFlush;     // record flush pulse
		logic                     recPushValid; // record sample to store
		logic [SAMPLE_W-1:0]      recPushData;  // record sample
	} ctrl_state_s;

	ctrl_state_s              q;          // registered state
	ctrl_state_s              n;          // next state
	logic [OFFSET_W-1:0]      offset;     // byte offset in region
	logic                     inRegion;   // address hits the region
	logic                     setupPhase; // first cycle of a transfer
	logic                     complete;   // transfer ends this edge without error
	logic                     rise;       // bit clock rising edge
	logic                     fall;       // bit clock falling edge
	logic                     frameStart; // first bit of a new frame
	logic [3:0]               ns;         // slot after this bit
	logic [4:0]               nb;         // bit after this bit
	logic [SLOT_W-1:0]        word;       // incoming word with newest bit
	logic [SLOT_W-1:0]        leftWord;   // left sample as slot
	logic [SLOT_W-1:0]        rightWord;  // right sample as slot
	logic [busDataWidth-1:0]  rdData;     // read mux
	logic                     accessOk;   // offset and direction legal
	logic                     playPush;   // bus writes a sample
	logic                     playPop;    // link takes a sample
	logic                     playReady;  // playback fifo not full
	logic                     playValid;  // playback fifo not empty
	logic [SAMPLE_W-1:0]      playData;   // playback head
	logic [LEVEL_W-1:0]       playLevel;  // playback fill
	logic                     recPop;     // bus reads a sample
	logic                     recReady;   // record fifo not full
	logic                     recValid;   // record fifo not empty
	logic [SAMPLE_W-1:0]      recData;    // record head
	logic [LEVEL_W-1:0]       recLevel;   // record fill

	// outputs straight from state flip-flops
	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign playbackIrq   = q.playIrq;
	assign recordIrq     = q.recIrq;
	assign frameSync     = q.sync;
	assign serialToCodec = q.sdo;

	// bus decode
	assign offset     = paddr[OFFSET_W-1:0];
	assign inRegion   = ((paddr & ~REGION_MASK) == regionStartAddress);
	assign setupPhase = psel & ~penable & ~q.pready;
	assign complete   = psel & penable & q.pready & ~q.pslverr;
	assign playPush   = complete & pwrite & (offset == OFF_PLAY_DATA);
	assign recPop     = complete & ~pwrite & (offset == OFF_REC_DATA) & recValid;

	// bit clock edges once synchroniser stages agree
	assign rise = (q.clkSync[1] == q.clkSync[2]) & q.clkSync[2] & ~q.clkLevel;
	assign fall = (q.clkSync[1] == q.clkSync[2]) & ~q.clkSync[2] & q.clkLevel;

	generate
		if (playbackEnable) begin : gPlay
			sample_fifo #(
				.WIDTH (SAMPLE_W),
				.DEPTH (FIFO_DEPTH)
			) uPlayFifo (
				.clock     (clock),
				.srst      (srst),
				.flush     (q.playFlush),
				.pushValid (playPush),
				.pushData  (pwdata[SAMPLE_W-1:0]),
				.pushReady (playReady),
				.popValid  (playValid),
				.popReady  (playPop),
				.popData   (playData),
				.level     (playLevel)
			);
		end else begin : gNoPlay
			assign playReady = 1'b0;
			assign playValid = 1'b0;
			assign playData  = '0;
			assign playLevel = '0;
		end
	endgenerate

	generate
		if (recordEnable) begin : gRec
			sample_fifo #(
				.WIDTH (SAMPLE_W),
				.DEPTH (FIFO_DEPTH)
			) uRecFifo (
				.clock     (clock),
				.srst      (srst),
				.flush     (q.recFlush),
				.pushValid (q.recPushValid),
				.pushData  (q.recPushData),
				.pushReady (recReady),
				.popValid  (recValid),
				.popReady  (recPop),
				.popData   (recData),
				.level     (recLevel)
			);
		end else begin : gNoRec
			assign recReady = 1'b0;
			assign recValid = 1'b0;
			assign recData  = '0;
			assign recLevel = '0;
		end
	endgenerate

	// register read mux and legality check
	always_comb begin
		rdData   = '0;
		accessOk = 1'b1;
		if (!inRegion) begin
			accessOk = 1'b0;
		end else if (pwrite) begin
			case (offset)
				// full or absent playback buffer refuses
				OFF_PLAY_DATA:   accessOk = playbackEnable & playReady;
				OFF_CONTROL:     accessOk = 1'b1;
				OFF_CODEC_ADDR:  accessOk = 1'b1;
				OFF_CODEC_WDATA: accessOk = 1'b1;
				default:         accessOk = 1'b0;
			endcase
		end else begin
			case (offset)
				OFF_REC_DATA: begin
					accessOk = recordEnable;
					// empty buffer reads as zero, its storage may be unwritten
					rdData   = recValid ? busDataWidth'(recData) : '0;
				end
				OFF_STATUS: begin
					rdData[ST_PLAY_FULL]   = ~playReady;
					rdData[ST_PLAY_EMPTY]  = ~playValid;
					rdData[ST_REC_FULL]    = ~recReady;
					rdData[ST_REC_EMPTY]   = ~recValid;
					rdData[ST_REC_OVERRUN] = q.overrun;
					rdData[ST_UNDERRUN]    = q.underrun;
					rdData[ST_CODEC_READY] = q.codecReady;
					rdData[ST_ACCESS_DONE] = q.accessDone;
				end
				OFF_CONTROL:     rdData = '0;
				OFF_CODEC_ADDR:  rdData = busDataWidth'(q.cmdAddr);
				OFF_CODEC_WDATA: rdData = busDataWidth'(q.cmdWdata);
				OFF_CODEC_RDATA: rdData = busDataWidth'(q.codecRdata);
				default:         accessOk = 1'b0;
			endcase
		end
	end

	// next state: bus, synchronisers, serial frame
	always_comb begin
		n            = q;
		playPop      = 1'b0;
		ns           = q.slot;
		nb           = q.slotBit;
		frameStart   = 1'b0;
		word         = {q.inShift[SLOT_W-2:0], q.dinSync[2]};
		n.playFlush  = 1'b0;
		n.recFlush   = 1'b0;
		n.recPushValid = 1'b0;

		// three-stage pin synchronisers
		n.clkSync = {q.clkSync[1:0], codecBitClock};
		n.dinSync = {q.dinSync[1:0], serialFromCodec};
		if (q.clkSync[1] == q.clkSync[2]) begin
			n.clkLevel = q.clkSync[2];
		end

		// answer in the first access cycle
		if (setupPhase) begin
			n.pready  = 1'b1;
			n.pslverr = ~accessOk;
			n.prdata  = accessOk ? rdData : '0;
		end else begin
			n.pready  = 1'b0;
			n.pslverr = 1'b0;
		end

		// register writes at the completing edge
		if (complete && pwrite) begin
			case (offset)
				OFF_CONTROL: begin
					n.playFlush = pwdata[CTRL_PLAY_FLUSH];
					n.recFlush  = pwdata[CTRL_REC_FLUSH];
				end
				OFF_CODEC_ADDR: begin
					n.cmdAddr    = pwdata[CODEC_INDEX_W:0];
					n.pending    = 1'b1;
					n.accessDone = 1'b0;
				end
				OFF_CODEC_WDATA: n.cmdWdata = pwdata[SAMPLE_W-1:0];
				default: n.cmdWdata = q.cmdWdata;
			endcase
		end

		// flush clears underrun before new sets
		if (q.playFlush) begin
			n.underrun  = 1'b0;
			n.playing   = 1'b0;
			n.takeRight = 1'b0;
		end
		// flush clears overrun before new sets
		if (q.recFlush) begin
			n.overrun = 1'b0;
		end

		// sample arriving at full buffer is lost
		if (q.recPushValid && !recReady && !q.recFlush) begin
			n.overrun = 1'b1;
		end

		// right sample follows left by one cycle
		if (q.takeRight && !q.playFlush) begin
			n.outRight  = playData;
			playPop     = 1'b1;
			n.takeRight = 1'b0;
		end

		// rising edge: advance and drive next bit
		if (rise) begin
			if (q.slotBit == '0) begin
				ns = (q.slot == SLOT_LAST) ? SLOT_TAG : 4'(q.slot + 4'h1);
				nb = (ns == SLOT_TAG) ? TAG_LAST_BIT : SLOT_LAST_BIT;
				frameStart = (q.slot == SLOT_LAST);
			end else begin
				nb = 5'(q.slotBit - 5'h01);
			end
			n.slot    = ns;
			n.slotBit = nb;
			if (frameStart) begin
				n.outTag            = '0;
				n.outTag[TAG_FRAME] = 1'b1;
				if (q.pending) begin
					n.pending          = 1'b0;
					n.inFlight         = 1'b1;
					n.outTag[TAG_ADDR] = 1'b1;
					n.outTag[TAG_DATA] = ~q.cmdAddr[CODEC_INDEX_W];
					n.outAddr          = {q.cmdAddr, {(SLOT_W-CODEC_INDEX_W-1){1'b0}}};
					n.outData          = {q.cmdWdata, {SAMPLE_LSB{1'b0}}};
				end
				// pop a left/right pair when one is there
				if (playbackEnable && playLevel >= PAIR_WORDS && !q.playFlush) begin
					n.outTag[TAG_LEFT]  = 1'b1;
					n.outTag[TAG_RIGHT] = 1'b1;
					n.outLeft           = playData;
					playPop             = 1'b1;
					n.takeRight         = 1'b1;
					n.playing           = 1'b1;
				end else if (q.playing && !q.playFlush) begin
					n.underrun = 1'b1;
				end
			end
			// sync high across the tag slot
			n.sync    = (ns == SLOT_TAG);
			leftWord  = {n.outLeft, {SAMPLE_LSB{1'b0}}};
			rightWord = {n.outRight, {SAMPLE_LSB{1'b0}}};
			case (ns)
				SLOT_TAG:   n.sdo = n.outTag[nb[3:0]];
				SLOT_ADDR:  n.sdo = n.outAddr[nb];
				SLOT_DATA:  n.sdo = n.outData[nb];
				SLOT_LEFT:  n.sdo = n.outTag[TAG_LEFT] & leftWord[nb];
				SLOT_RIGHT: n.sdo = n.outTag[TAG_RIGHT] & rightWord[nb];
				default:    n.sdo = 1'b0;
			endcase
		end else begin
			leftWord  = '0;
			rightWord = '0;
		end

		if (fall) begin
			n.inShift = word;
			if (q.slotBit == '0) begin
				case (q.slot)
					SLOT_TAG: begin
						n.inTag      = word[TAG_W-1:0];
						n.codecReady = word[TAG_FRAME];
					end
					SLOT_DATA: begin
						// write done once its data slot went out
						if (q.inFlight && !q.outAddr[SLOT_W-1]) begin
							n.inFlight   = 1'b0;
							n.accessDone = 1'b1;
						// read answer comes in a later frame
						end else if (q.inFlight && !q.outTag[TAG_ADDR] && q.inTag[TAG_DATA]) begin
							n.inFlight   = 1'b0;
							n.accessDone = 1'b1;
							n.codecRdata = word[SLOT_W-1:SAMPLE_LSB];
						end
					end
					SLOT_LEFT: begin
						n.recPushValid = recordEnable & q.inTag[TAG_LEFT];
						n.recPushData  = word[SLOT_W-1:SAMPLE_LSB];
					end
					SLOT_RIGHT: begin
						n.recPushValid = recordEnable & q.inTag[TAG_RIGHT];
						n.recPushData  = word[SLOT_W-1:SAMPLE_LSB];
					end
					default: n.inShift = word;
				endcase
			end
		end

		n.playIrq = playbackEnable & thresholdMet(playbackIrqThresholdSel, playLevel);
		n.recIrq  = recordEnable & thresholdMet(recordIrqThresholdSel, recLevel);
	end

	// one clock, synchronous reset to idle
	always_ff @(posedge clock) begin
		if (srst) begin
			q         <= '0;
			q.slot    <= SLOT_LAST;
			q.slotBit <= 5'h00;
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// [tb/acb_props.sv]
// bus handshake and link framing checks on the controller pins
`timescale 1ns/1ps
`default_nettype none
module acb_props
	import audio_codec_pkg::*;
#(
	parameter int busAddressWidth = 32
)(
	input wire logic                       clock,
	input wire logic                       srst,
	input wire logic [busAddressWidth-1:0] paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       recordIrq,
	input wire logic                       frameSync,
	input wire logic                       serialToCodec
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// cycles that frame sync has stayed high
	logic [9:0] syncLen;
	always_ff @(posedge clock) begin
		syncLen <= (srst || !frameSync) ? 10'h000 : syncLen + 10'h001;
	end
	chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	chk_ready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
	chk_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	chk_unmapped_err: assert property (psel && !penable && paddr[7:0] > OFF_CODEC_RDATA |=> pslverr)
		else $error("unmapped offset accepted");
	chk_play_read_err: assert property (psel && !penable && !pwrite && paddr[7:0] == OFF_PLAY_DATA |=> pslverr)
		else $error("playback read accepted");
	chk_sync_width: assert property ($fell(frameSync) |-> syncLen inside {[10'h1fc:10'h204]})
		else $error("sync width wrong");
	chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0) srst |=> !frameSync && !serialToCodec && !pready)
		else $error("outputs busy in reset");
	cover property (pslverr);
	cover property ($fell(frameSync));
	cover property ($rose(recordIrq));
endmodule
bind audio_codec_bus_controller acb_props #(.busAddressWidth(busAddressWidth)) i_props (.clock(clock), .srst(srst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.recordIrq(recordIrq), .frameSync(frameSync), .serialToCodec(serialToCodec));
`default_nettype wire

// [tb/codec_model.sv]
// behavioural codec: bit clock, record frames, playback capture
`timescale 1ns/1ps
`default_nettype none
module codec_model(
	input  wire logic        run,
	input  wire logic        serialToCodec,
	output logic             codecBitClock,
	output logic             serialFromCodec,
	output logic             evValid,
	output logic [23:0]      evData,
	output int               frameCnt
);
	localparam logic [15:0] TAG_IN = 16'h9800;
	logic [19:0] sh;
	logic [15:0] tag, lft, rgt;
	logic [7:0]  cmd;
	int          k;
	// clock stands still between frames unless run
	initial begin
		{codecBitClock, serialFromCodec, evValid, sh, tag, cmd} = '0;
		k = 0;
		frameCnt = 0;
		forever begin
			// bit clock 160 ns, far below the 5 ns bus clock
			#80;
			if (run || k != 0) begin
				lft = 16'h1100 + 16'(frameCnt);
				rgt = 16'h2200 + 16'(frameCnt);
				codecBitClock = 1'b1;
				evValid = 1'b0;
				if (k < 16) serialFromCodec = TAG_IN[15-k];
				else if (k >= 56 && k < 72) serialFromCodec = lft[71-k];
				else if (k >= 76 && k < 92) serialFromCodec = rgt[91-k];
				else serialFromCodec = 1'b0;
				#80;
				codecBitClock = 1'b0;
				sh = {sh[18:0], serialToCodec};
				if (k == 15) tag = sh[15:0];
				if (k == 35) cmd = sh[19:12];
				if ((k == 55 && tag[14]) || (k == 75 && tag[12]) || (k == 95 && tag[11])) begin
					evData = {(k == 55) ? cmd : 8'h00, sh[19:4]};
					evValid = 1'b1;
				end
				k = (k + 1) % 256;
				if (k == 0) frameCnt++;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the audio codec bus controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import audio_codec_pkg::*;
	localparam logic [32:0] ERRM = 33'h1_0000_0000;
	localparam logic [32:0] ALLM = 33'h1_ffff_ffff;
	localparam logic [31:0] REGION_BASE = 32'h4000_0100;
	logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic        pready, pslverr, playbackIrq, recordIrq, codecBitClock, frameSync, serialToCodec;
	logic        serialFromCodec, evValid;
	logic [23:0] evData, evQ[$];
	logic [15:0] lfsr = 16'hd7e3;
	logic [32:0] expQ[$], mskQ[$];
	int          error_cnt = 0, cmp_count = 0, frameCnt, n;
	always #2.5 clock = ~clock;
	// base on 256-byte boundary, power-of-two span, 32-bit bus
	audio_codec_bus_controller #(.busAddressWidth(32), .busDataWidth(32),
		.regionStartAddress(REGION_BASE), .regionEndAddress(REGION_BASE + 32'h0000_00ff))
		i_dut (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .playbackIrq(playbackIrq), .recordIrq(recordIrq), .codecBitClock(codecBitClock),
		.frameSync(frameSync), .serialToCodec(serialToCodec), .serialFromCodec(serialFromCodec));
	codec_model i_codec (.run(run), .serialToCodec(serialToCodec), .codecBitClock(codecBitClock),
		.serialFromCodec(serialFromCodec), .evValid(evValid), .evData(evData), .frameCnt(frameCnt));
	function automatic logic [15:0] nextRand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task end_of_test;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer, expected response noted first
	task apb(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
		@(posedge clock);
		expQ.push_back(e);
		mskQ.push_back(m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= REGION_BASE + 32'(a);
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			end_of_test;
		end
	endtask
	always @(posedge clock) if (psel && penable && pready && expQ.size() > 0) chk({pslverr, prdata} & mskQ.pop_front(), expQ.pop_front());
	// compare each word seen by the codec
	always @(posedge evValid) chk({9'h000, evData}, {9'h000, evQ.pop_front()});
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (2) @(posedge clock);
		chk({32'h0, playbackIrq}, 33'h1);
		chk({32'h0, recordIrq}, 33'h0);
		apb(0, OFF_STATUS, 0, 33'h0_0000_000a, 33'h1_0000_003f);
		apb(1, OFF_CODEC_WDATA, {16'h0000, lfsr}, 0, ERRM);
		apb(1, OFF_CODEC_ADDR, 32'h0000_002a, 0, ERRM);
		evQ.push_back({8'h2a, lfsr});
		repeat (16) begin
			lfsr = nextRand(lfsr);
			apb(1, OFF_PLAY_DATA, {16'h0000, lfsr}, 0, ERRM);
			evQ.push_back({8'h00, lfsr});
		end
		apb(1, OFF_PLAY_DATA, 0, ERRM, ERRM);
		chk({32'h0, playbackIrq}, 33'h0);
		apb(0, OFF_PLAY_DATA, 0, ERRM, ERRM);
		apb(0, 8'h1c, 0, ERRM, ERRM);
		apb(0, OFF_REC_DATA, 0, 0, ALLM);
		$display("bus phase done");
		run <= 1'b1;
		n = 0;
		while (frameCnt < 9 && n < 90000) begin
			@(posedge clock);
			n++;
		end
		run <= 1'b0;
		if (n >= 90000) begin
			error_cnt++;
			end_of_test;
		end
		chk({32'h0, recordIrq}, 33'h1);
		apb(0, OFF_STATUS, 0, 33'h0_0000_00f6, 33'h1_0000_00ff);
		for (int f = 0; f < 8; f++) begin
			apb(0, OFF_REC_DATA, 0, {17'h0_0000, 16'h1100 + 16'(f)}, ALLM);
			apb(0, OFF_REC_DATA, 0, {17'h0_0000, 16'h2200 + 16'(f)}, ALLM);
		end
		repeat (3) @(posedge clock);
		chk({32'h0, recordIrq}, 33'h0);
		$display("link phase done");
		apb(1, OFF_CONTROL, 32'h0000_0003, 0, ERRM);
		apb(0, OFF_STATUS, 0, 33'h0_0000_00ca, 33'h1_0000_00ff);
		apb(0, OFF_CODEC_ADDR, 0, 33'h0_0000_002a, ALLM);
		apb(0, OFF_CODEC_WDATA, 0, 33'h0_0000_d7e3, ALLM);
		apb(0, 9'h108, 0, ERRM, ERRM);
		repeat (3) @(posedge clock);
		$display("flush phase done");
		end_of_test;
	end
endmodule
`default_nettype wire
